// >>> rtc_core.sv
// Purpose: clock/calendar registers, user RAM, oscillator flag and square wave
// Assumes: osc_clk runs at twice the crystal rate; commands come from a
//          serial engine on clk
// Notes:   counting chain on clk, divider and wave pin on osc_clk
// What this block does
// - years divisible by four get February 29
// - rate code selects 1, 4k, 8k, 32k
// - only low six address bits are used
// - oscillator disable stops divider, chain stays
// - wave disabled: pin follows output level bit
// - wave enabled: pin shows selected frequency
// - seconds advance on falling 1 Hz edge
// - stop flag set once oscillator has stopped for OSF_CYC cycles
// - flag set at power-up and on disable
// - flag holds until host writes zero
// - fixed-zero bits always read zero
// - 56 RAM bytes at 08 to 3F
// - BCD time and date at 00 to 06
// - hours bit 6 mode, bit 5 PM/tens
// - recovery delay only while oscillator runs
// - host reads and writes all time registers
// - stop flag after about 100 ms stopped
// - address advances after every byte
`include "rtc_regs.svh"
`timescale 1ns/10ps
module rtc_core #(
    parameter int unsigned OSF_CYC = `RTC_OSF_CYC,
    parameter int unsigned REC_CYC = `RTC_REC_CYC,
    parameter int unsigned RUN_CYC = `RTC_RUN_CYC
) (
    // register clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // oscillator clock
    input  wire logic            osc_clk,
    // byte command port
    input  wire rtc_pkg::rtc_cmd_t cmd,
    output logic                 reg_ready,
    output logic [7:0]           reg_rdata,
    // square-wave output
    output logic                 square_wave_pin
);
    import rtc_pkg::*;

    localparam logic [21:0] OSF_N = 22'(OSF_CYC);
    localparam logic [15:0] REC_N = 16'(REC_CYC);
    localparam logic [21:0] RUN_N = 22'(RUN_CYC);
    // control reset split into its fields; a plain cast of the byte would keep only the low nibble
    localparam logic [7:0] CTRL_RST = `RTC_R_CTRL;
    localparam rtc_wave_t  WAVE_RST = '{out:  CTRL_RST[`RTC_B_OUT],
                                        wen:  CTRL_RST[`RTC_B_WEN],
                                        rate: CTRL_RST[1:0]};

    // BCD increment with wrap: returns {wrapped, next}
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [8:0] r;
        r = {1'b0, v + 8'h01};
        if (v >= hi)
            r = {1'b1, lo};
        else if (v[3:0] == 4'h9)
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        return r;
    endfunction

    // reset release, clk domain
    logic rs1_q, rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // reset release, oscillator domain
    logic ors1_q, orst_n;
    always_ff @(posedge osc_clk or negedge resetn) begin
        if (!resetn) begin
            ors1_q <= 1'b0;
            orst_n <= 1'b0;
        end else begin
            ors1_q <= 1'b1;
            orst_n <= ors1_q;
        end
    end

    // register state
    logic [7:0]  tm_q [0:6];
    logic [7:0]  ram_q [8:63];
    logic        osc_dis_q;
    logic        osf_q;
    rtc_wave_t   wave_q;
    logic [5:0]  ptr_q;
    rtc_rec_t    rec_q;
    logic [15:0] rec_cnt_q;
    logic [21:0] idle_q;

    // command decode
    wire        acc_ok  = (rec_q == RTC_REC_READY);
    wire        do_wr   = acc_ok & cmd.wr & ~cmd.start;
    wire        do_rd   = acc_ok & cmd.rd & ~cmd.start;
    wire [5:0]  start_a = cmd.addr[5:0];
    wire        wr_sec  = do_wr & (ptr_q == `RTC_A_SEC);
    wire        wr_ctrl = do_wr & (ptr_q == `RTC_A_CTRL);
    assign reg_ready = acc_ok;

    // oscillator domain: control crossing, divider, wave pin
    rtc_wave_t  wv1_q, wv2_q;
    logic       en1_q, en2_q;
    logic [15:0] div_q;
    logic       sec_tgl_q;
    always_ff @(posedge osc_clk or negedge orst_n) begin
        if (!orst_n) begin
            wv1_q <= WAVE_RST;
            wv2_q <= WAVE_RST;
            en1_q <= 1'b1;
            en2_q <= 1'b1;
        end else begin
            wv1_q <= wave_q;
            wv2_q <= wv1_q;
            en1_q <= ~osc_dis_q;
            en2_q <= en1_q;
        end
    end

    // divider halts while disabled; tick toggles at the 1 Hz falling edge
    always_ff @(posedge osc_clk or negedge orst_n) begin
        if (!orst_n) begin
            div_q     <= 16'h0000;
            sec_tgl_q <= 1'b0;
        end else if (en2_q) begin
            div_q     <= div_q + 16'h0001;
            sec_tgl_q <= sec_tgl_q ^ (div_q == 16'hFFFF);
        end
    end

    // rate select taps the divider; osc_clk is twice the crystal rate
    logic wave_sel;
    always_comb begin
        unique case (rtc_rate_t'(wv2_q.rate))
            RTC_RATE_1HZ: wave_sel = div_q[15];
            RTC_RATE_4K:  wave_sel = div_q[3];
            RTC_RATE_8K:  wave_sel = div_q[2];
            RTC_RATE_32K: wave_sel = div_q[0];
        endcase
    end
    always_ff @(posedge osc_clk or negedge orst_n) begin
        if (!orst_n)
            square_wave_pin <= 1'b1;
        else
            square_wave_pin <= wv2_q.wen ? wave_sel : wv2_q.out;
    end

    // tick and activity cross into clk; third stage feeds the edge detect
    logic [2:0] tk_q, ac_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tk_q <= 3'h0;
            ac_q <= 3'h0;
        end else begin
            tk_q <= {tk_q[1:0], sec_tgl_q};
            ac_q <= {ac_q[1:0], div_q[3]};
        end
    end
    wire tick    = tk_q[2] ^ tk_q[1];
    wire act     = ac_q[2] ^ ac_q[1];
    wire stopped = (idle_q >= RUN_N);
    wire stop_ev = (idle_q == OSF_N);

    // idle counter since the last divider edge, saturating past the flag point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            idle_q <= 22'h000000;
        else if (act)
            idle_q <= 22'h000000;
        else if (idle_q <= OSF_N)
            idle_q <= idle_q + 22'h000001;
    end

    // calendar carry chain
    wire [8:0] sec_n  = bcd_inc({1'b0, tm_q[0][6:0]}, 8'h00, 8'h59);
    wire [8:0] min_n  = bcd_inc(tm_q[1], 8'h00, 8'h59);
    wire       h12    = tm_q[2][6];
    wire       pm     = tm_q[2][5];
    wire [8:0] h24_n  = bcd_inc({2'b00, tm_q[2][5:0]}, 8'h00, 8'h23);
    wire [8:0] h12_n  = bcd_inc({3'b000, tm_q[2][4:0]}, 8'h01, 8'h12);
    wire       at11   = (tm_q[2][4:0] == 5'h11);
    wire [7:0] hour_n = h12 ? {2'b01, pm ^ at11, h12_n[4:0]} : {2'b00, h24_n[5:0]};
    wire       hour_c = h12 ? (at11 & pm) : h24_n[8];
    wire [8:0] wday_n = bcd_inc(tm_q[3], 8'h01, 8'h07);
    wire       leap   = tm_q[6][4] ? (tm_q[6][3:0] == 4'h2 || tm_q[6][3:0] == 4'h6)
                                   : (tm_q[6][1:0] == 2'b00);
    wire       m30    = (tm_q[5] == 8'h04) | (tm_q[5] == 8'h06) |
                        (tm_q[5] == 8'h09) | (tm_q[5] == 8'h11);
    wire [7:0] dim    = (tm_q[5] == 8'h02) ? (leap ? 8'h29 : 8'h28) : (m30 ? 8'h30 : 8'h31);
    wire [8:0] date_n = bcd_inc(tm_q[4], 8'h01, dim);
    wire [8:0] mon_n  = bcd_inc(tm_q[5], 8'h01, 8'h12);
    wire [8:0] year_n = bcd_inc(tm_q[6], 8'h00, 8'h99);
    wire [6:0] adv;
    assign adv[0] = tick;
    assign adv[1] = adv[0] & sec_n[8];
    assign adv[2] = adv[1] & min_n[8];
    assign adv[3] = adv[2] & hour_c;
    assign adv[4] = adv[3];
    assign adv[5] = adv[4] & date_n[8];
    assign adv[6] = adv[5] & mon_n[8];
    wire [7:0] nxt [0:6];
    assign nxt[0] = {1'b0, sec_n[6:0]};
    assign nxt[1] = min_n[7:0];
    assign nxt[2] = hour_n;
    assign nxt[3] = wday_n[7:0];
    assign nxt[4] = date_n[7:0];
    assign nxt[5] = mon_n[7:0];
    assign nxt[6] = year_n[7:0];
    wire [7:0] rmask [0:7];
    assign rmask[0] = `RTC_M_SEC;
    assign rmask[1] = `RTC_M_MIN;
    assign rmask[2] = `RTC_M_HOUR;
    assign rmask[3] = `RTC_M_WDAY;
    assign rmask[4] = `RTC_M_DATE;
    assign rmask[5] = `RTC_M_MON;
    assign rmask[6] = `RTC_M_YEAR;
    assign rmask[7] = `RTC_M_CTRL;

    // time registers: a host write beats a tick on the same register
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_tm
            wire wr_me = do_wr & (ptr_q == 6'(gi));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    tm_q[gi] <= (gi == 3 || gi == 4 || gi == 5) ? `RTC_R_ONE : `RTC_R_ZERO;
                else if (wr_me)
                    tm_q[gi] <= cmd.wdata & rmask[gi] & 8'h7F | cmd.wdata & rmask[gi] & 8'h80 & {8{gi != 0}};
                else if (adv[gi])
                    tm_q[gi] <= nxt[gi];
            end
        end
    endgenerate

    // user RAM, no reset needed
    always_ff @(posedge clk) begin
        if (do_wr && ptr_q >= `RTC_A_RAM_LO)
            ram_q[ptr_q] <= cmd.wdata;
    end

    // control, disable bit and stop flag; a set wins over a clear
    wire osf_set = stop_ev | (wr_sec & cmd.wdata[`RTC_B_OSCD]);
    wire osf_clr = wr_ctrl & ~cmd.wdata[`RTC_B_OSF];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_dis_q <= 1'b0;
            osf_q     <= 1'b1;
            wave_q    <= WAVE_RST;
        end else begin
            if (wr_sec)
                osc_dis_q <= cmd.wdata[`RTC_B_OSCD];
            if (wr_ctrl)
                wave_q <= {cmd.wdata[`RTC_B_OUT], cmd.wdata[`RTC_B_WEN], cmd.wdata[1:0]};
            osf_q <= osf_set | (osf_q & ~osf_clr);
        end
    end

    // address pointer and read data
    wire [7:0] ctrl_rd = {wave_q.out, 1'b0, osf_q, wave_q.wen, 2'b00, wave_q.rate};
    wire [7:0] rd_val  = (ptr_q >= `RTC_A_RAM_LO) ? ram_q[ptr_q] :
                         (ptr_q == `RTC_A_CTRL)   ? ctrl_rd :
                         (ptr_q == `RTC_A_SEC)    ? {osc_dis_q, tm_q[0][6:0]} :
                         tm_q[ptr_q[2:0]] & rmask[ptr_q[2:0]];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q     <= 6'h00;
            reg_rdata <= 8'h00;
        end else begin
            if (acc_ok && cmd.start)
                ptr_q <= start_a;
            else if (do_wr || do_rd)
                ptr_q <= ptr_q + 6'h01;
            if (do_rd)
                reg_rdata <= rd_val;
        end
    end

    // power-up recovery: hold off only while the oscillator runs
    wire rec_done = (rec_cnt_q == REC_N - 16'h0001) | osc_dis_q | stopped;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_q     <= RTC_REC_WAIT;
            rec_cnt_q <= 16'h0000;
        end else begin
            unique case (rec_q)
                RTC_REC_WAIT: begin
                    rec_cnt_q <= rec_cnt_q + 16'h0001;
                    if (rec_done)
                        rec_q <= RTC_REC_READY;
                end
                RTC_REC_READY: rec_q <= RTC_REC_READY;
            endcase
        end
    end

    // checks, clk domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_start;
        acc_ok && cmd.start;
    endsequence
    sequence s_byte;
        do_wr || do_rd;
    endsequence
    addr_wrap_a: assert property (s_start |=> ptr_q == $past(cmd.addr[5:0]))
        else $error("start address not cut to six bits");
    ptr_step_a: assert property (s_byte |=> ptr_q == $past(ptr_q) + 6'h01)
        else $error("pointer did not advance");
    flag_hold_a: assert property (osf_q && !osf_clr |=> osf_q)
        else $error("stop flag dropped without a zero write");
    flag_dis_a: assert property (wr_sec && cmd.wdata[7] |=> osf_q && osc_dis_q)
        else $error("disable write did not set flag");
    flag_stop_a: assert property (stop_ev |=> osf_q)
        else $error("long stop did not set flag");
    zero_read_a: assert property (do_rd && ptr_q == `RTC_A_WDAY |=> reg_rdata[7:3] == 5'h00)
        else $error("fixed bits read nonzero");
    ctrl_zero_a: assert property (do_rd && ptr_q == `RTC_A_CTRL |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'b00)
        else $error("control fixed bits read nonzero");
    sec_wrap_a: assert property (tick && !do_wr && tm_q[0][6:0] == 7'h59
                                 |=> tm_q[0][6:0] == 7'h00)
        else $error("seconds did not wrap");
    // a stalled or disabled oscillator must not hold the port off
    rec_fast_a: assert property (rec_q == RTC_REC_WAIT && (osc_dis_q || stopped) |=> reg_ready)
        else $error("recovery held with oscillator off");
    rec_hold_a: assert property (rec_q == RTC_REC_WAIT && !rec_done |=> !reg_ready)
        else $error("access given during recovery");
    // check, oscillator domain
    wave_dc_a: assert property (@(posedge osc_clk) disable iff (!orst_n) !wv2_q.wen |=>
                                square_wave_pin == $past(wv2_q.out))
        else $error("pin does not follow level bit");
    // enabled: the pin is the selected divider tap one edge later
    wave_on_a: assert property (@(posedge osc_clk) disable iff (!orst_n) wv2_q.wen |=>
                                square_wave_pin == $past(wave_sel))
        else $error("pin does not show selected rate");
endmodule // rtc_core

// >>> rtc_host.sv
// Purpose: host side of the register port, one command per serial byte
// Assumes: commands change just after a rising clk edge
// Notes:   serial framing is abstracted away; the block sees only bytes
`timescale 1ns/10ps
module rtc_host (
    // clock and handshake
    input  wire logic          clk,
    input  wire logic          reg_ready,
    input  wire logic [7:0]    reg_rdata,
    // command to the block
    output rtc_pkg::rtc_cmd_t  cmd
);
    import rtc_pkg::*;
    initial cmd = '0;
    // hold a command until an edge sees ready; bytes follow back to back, the slow bus is not paced
    task automatic issue(input logic s, input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        cmd <= '{start: s, wr: w, rd: r, addr: a, wdata: d};
        do @(posedge clk); while (reg_ready !== 1'b1);
    endtask
    // pointer load then back-to-back write bytes
    task automatic wr(input logic [7:0] a, input logic [7:0] bytes [$]);
        issue(1'b1, 1'b0, 1'b0, a, 8'h00);
        foreach (bytes[i]) issue(1'b0, 1'b1, 1'b0, 8'h00, bytes[i]);
        cmd <= '0;
        @(posedge clk);
    endtask
    // pointer load then one read byte, taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        issue(1'b1, 1'b0, 1'b0, a, 8'h00);
        issue(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
        cmd <= '0;
        @(posedge clk);
        #1 q = reg_rdata;
    endtask
endmodule // rtc_host

// >>> rtc_pkg.sv
// Purpose: shared types of the clock/calendar register block
// Assumes: nothing
// Notes:   numbers live in rtc_regs.svh
package rtc_pkg;
    // byte command from the serial engine
    typedef struct packed {
        logic       start;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtc_cmd_t;
    // square-wave control fields
    typedef struct packed {
        logic       out;
        logic       wen;
        logic [1:0] rate;
    } rtc_wave_t;
    typedef enum logic [1:0] {
        RTC_RATE_1HZ = 2'b00,
        RTC_RATE_4K  = 2'b01,
        RTC_RATE_8K  = 2'b10,
        RTC_RATE_32K = 2'b11
    } rtc_rate_t;
    typedef enum logic [0:0] {
        RTC_REC_WAIT  = 1'b0,
        RTC_REC_READY = 1'b1
    } rtc_rec_t;
endpackage

// >>> rtc_regmap_sqw_control_tb.sv
// Purpose: self-checking bench of the clock/calendar register block
// Assumes: shortened stop, recovery and idle counts
// Notes:   one calendar tick is waited for, so the run is a few ms long
`timescale 1ns/10ps
module rtc_regmap_sqw_control_tb;
    import rtc_pkg::*;
    localparam int unsigned OSF_N = 200;
    localparam int unsigned REC_N = 150;
    localparam int unsigned RUN_N = 64;
    logic       clk;
    logic       resetn;
    logic       osc_clk;
    logic       osc_run;
    rtc_cmd_t   cmd;
    logic       reg_ready;
    logic [7:0] reg_rdata;
    logic       square_wave_pin;
    logic [7:0] q;
    int         num_errors;
    int         n_compared;
    int         cycles;
    // register clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // crystal stand-in; gating it models a stopped oscillator
    initial begin
        osc_run = 1'b1;
        osc_clk = 1'b0;
        #7;
        forever #24 osc_clk = osc_run ? ~osc_clk : 1'b0;
    end
    rtc_core #(.OSF_CYC(OSF_N), .REC_CYC(REC_N), .RUN_CYC(RUN_N)) u_dut (
        .clk(clk), .resetn(resetn), .osc_clk(osc_clk), .cmd(cmd),
        .reg_ready(reg_ready), .reg_rdata(reg_rdata), .square_wave_pin(square_wave_pin));
    rtc_host u_host (.clk(clk), .reg_ready(reg_ready), .reg_rdata(reg_rdata), .cmd(cmd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard: the calendar tick alone needs about 64k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            num_errors++;
            close_out();
        end
    end
    // access withheld during recovery, then reset values
    task automatic t_reset();
        logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'hB3};
        int n;
        repeat (5) @(posedge clk);
        chk({7'h00, reg_ready}, 8'h00);
        n = 0;
        while (reg_ready !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        foreach (e[i]) begin
            u_host.rd(8'(i), q);
            chk(q, e[i]);
        end
        $display("reset test done");
    endtask
    // fixed-zero bits, hour mode bits and stop flag write rules
    task automatic t_masks();
        logic [7:0] m [7] = '{8'h7F, 8'h7F, 8'h07, 8'h3F, 8'h1F, 8'hFF, 8'hB3};
        foreach (m[i]) begin
            u_host.wr(8'(i + 1), {8'hFF});
            u_host.rd(8'(i + 1), q);
            chk(q, m[i]);
        end
        u_host.wr(8'h02, {8'h71});
        u_host.rd(8'h02, q);
        chk(q, 8'h71);
        u_host.wr(8'h07, {8'h00});
        u_host.rd(8'h07, q);
        chk(q, 8'h00);
        u_host.wr(8'h07, {8'h20});
        u_host.rd(8'h07, q);
        chk(q, 8'h00);
        $display("mask test done");
    endtask
    // user storage, auto-increment and upper address bits ignored
    task automatic t_ram();
        u_host.wr(8'h48, {8'hA1, 8'hA2});
        u_host.wr(8'h7F, {8'h5A});
        u_host.rd(8'h08, q);
        chk(q, 8'hA1);
        u_host.rd(8'h09, q);
        chk(q, 8'hA2);
        u_host.rd(8'h3F, q);
        chk(q, 8'h5A);
        $display("ram test done");
    endtask
    // level output and the three fast rates, counted in pin transitions
    task automatic t_wave();
        int sh [3] = '{3, 2, 0};
        int n;
        logic p;
        u_host.wr(8'h07, {8'h00});
        repeat (6) @(negedge osc_clk);
        chk({7'h00, square_wave_pin}, 8'h00);
        u_host.wr(8'h07, {8'h80});
        repeat (6) @(negedge osc_clk);
        chk({7'h00, square_wave_pin}, 8'h01);
        foreach (sh[i]) begin
            u_host.wr(8'h07, {8'h11 + 8'(i)});
            repeat (8) @(negedge osc_clk);
            n = 0;
            p = square_wave_pin;
            repeat (64) begin
                @(negedge osc_clk);
                if (square_wave_pin !== p) n++;
                p = square_wave_pin;
            end
            chk({7'h00, n >= (64 >> sh[i]) - 1 && n <= (64 >> sh[i]) + 1}, 8'h01);
        end
        $display("wave test done");
    endtask
    // carry from 23:59:59 on 28 Feb of a leap year into 29 Feb at the 1 Hz falling edge
    task automatic t_tick();
        logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04};
        int n;
        u_host.wr(8'h00, {8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04});
        u_host.wr(8'h07, {8'h10});
        // let the new rate cross, or a fast-rate edge passes for the 1 Hz one
        repeat (8) @(posedge osc_clk);
        n = 0;
        while (square_wave_pin !== 1'b1 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        while (square_wave_pin !== 1'b0 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        repeat (20) @(posedge clk);
        foreach (e[i]) begin
            u_host.rd(8'(i), q);
            chk(q, e[i]);
        end
        $display("tick test done");
    endtask
    // stop flag after a stall and on oscillator disable
    task automatic t_stop();
        u_host.wr(8'h07, {8'h00});
        osc_run = 1'b0;
        repeat (RUN_N + 100) @(posedge clk);
        u_host.rd(8'h07, q);
        chk(q & 8'h20, 8'h00);
        repeat (OSF_N + 50) @(posedge clk);
        u_host.rd(8'h07, q);
        chk(q & 8'h20, 8'h20);
        osc_run = 1'b1;
        repeat (20) @(posedge clk);
        u_host.wr(8'h07, {8'h00});
        u_host.wr(8'h00, {8'h80});
        u_host.rd(8'h07, q);
        chk(q & 8'h20, 8'h20);
        u_host.rd(8'h00, q);
        chk(q, 8'h80);
        $display("stop test done");
    endtask
    // mid-run reset with the oscillator stalled: no full recovery wait, power-up values back
    task automatic t_cold();
        int n;
        osc_run = 1'b0;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        n = 0;
        while (reg_ready !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, n >= RUN_N && n < REC_N}, 8'h01);
        u_host.rd(8'h07, q);
        chk(q, 8'hB3);
        u_host.rd(8'h00, q);
        chk(q, 8'h00);
        osc_run = 1'b1;
        $display("cold start test done");
    endtask
    // main sequence
    initial begin
        num_errors = 0;
        n_compared = 0;
        cycles = 0;
        resetn = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_masks();
        t_ram();
        t_wave();
        t_tick();
        t_stop();
        t_cold();
        close_out();
    end
endmodule // rtc_regmap_sqw_control_tb

// >>> rtc_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 20 MHz register clock, oscillator clock at twice the crystal rate
// Notes:   definitions only
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// register offsets (6-bit address space)
`define RTC_A_SEC     6'h00
`define RTC_A_MIN     6'h01
`define RTC_A_HOUR    6'h02
`define RTC_A_WDAY    6'h03
`define RTC_A_DATE    6'h04
`define RTC_A_MON     6'h05
`define RTC_A_YEAR    6'h06
`define RTC_A_CTRL    6'h07
`define RTC_A_RAM_LO  6'h08
// read masks: fixed-zero bits are cleared
`define RTC_M_SEC     8'hFF
`define RTC_M_MIN     8'h7F
`define RTC_M_HOUR    8'h7F
`define RTC_M_WDAY    8'h07
`define RTC_M_DATE    8'h3F
`define RTC_M_MON     8'h1F
`define RTC_M_YEAR    8'hFF
`define RTC_M_CTRL    8'hB3
// control field positions
`define RTC_B_OUT     7
`define RTC_B_OSF     5
`define RTC_B_WEN     4
`define RTC_B_OSCD    7
// reset values
`define RTC_R_CTRL    8'hB3
`define RTC_R_ZERO    8'h00
`define RTC_R_ONE     8'h01
// timing
`define RTC_CLK_HZ    20000000
`define RTC_T_OSF_MS  100
`define RTC_T_REC_MS  2
`define RTC_OSF_CYC   (`RTC_T_OSF_MS * (`RTC_CLK_HZ / 1000))
`define RTC_REC_CYC   (`RTC_T_REC_MS * (`RTC_CLK_HZ / 1000))
`define RTC_RUN_CYC   8192
`endif
